// *** hdl/dpbr_pkg.sv ***
/*
 * Constants and types shared by the dual-port block memory.
 * Assumes one system clock, aclk, and an AXI4-Lite master outside.
 */
package dpbr_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ADDR_W      = 14;
    localparam int WORD_W      = 32;
    localparam int PAR_W       = 4;
    localparam int IDX_W       = 9;
    localparam int WORDS       = 512;
    localparam int PORTS       = 2;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // Port widths and write modes
    // ************************************************************
    typedef enum logic [2:0] {
        DPBR_W1,
        DPBR_W2,
        DPBR_W4,
        DPBR_W9,
        DPBR_W18,
        DPBR_W36
    } dpbr_width_e;

    typedef enum logic [1:0] {
        DPBR_WRITE_THROUGH,
        DPBR_READ_BEFORE_WRITE,
        DPBR_NO_CHANGE
    } dpbr_mode_e;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          AXI_ADDR_W    = 12;
    localparam logic [11:0] REG_CFG       = 12'h000;
    localparam logic [11:0] REG_STAT      = 12'h004;
    localparam int          CFG_WIDTH_LSB = 0;
    localparam int          CFG_MODE_LSB  = 8;
    localparam int          CFG_FALL_BIT  = 16;
    localparam int          CFG_PORT_STEP = 4;
    localparam int          STAT_CNT_W    = 16;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0055;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : dpbr_pkg

// *** hdl/dpbr_port.sv ***
/*
 * One access port of the dual-port memory: brings the port clock and
 * port inputs into the aclk domain, finds the active port clock edge
 * and maps the address onto a word, a bit lane and a parity lane.
 * Assumes port inputs are held steady around each port clock edge.
 */
`timescale 1ns/10ps
module dpbr_port (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     port_clk,
    input  wire logic                     select,
    input  wire logic                     write_strobe,
    input  wire logic [13:0]              addr,
    input  wire logic [31:0]              wr_data,
    input  wire logic [3:0]               wr_par,
    input  wire dpbr_pkg::dpbr_width_e    width,
    input  wire logic                     falling,
    input  wire logic [31:0]              rd_word,
    input  wire logic [3:0]               rd_par,
    output logic                          fire,
    output logic                          wr,
    output logic [8:0]                    word_idx,
    output logic [31:0]                   bit_mask,
    output logic [31:0]                   bit_data,
    output logic [3:0]                    par_mask,
    output logic [3:0]                    par_data,
    output logic [31:0]                   rd_data,
    output logic [3:0]                    rd_parity,
    output logic [31:0]                   thru_data,
    output logic [3:0]                    thru_par
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0]  clk_sh;
        logic [1:0]  sel_sh;
        logic [1:0]  we_sh;
        logic [13:0] addr1;
        logic [13:0] addr2;
        logic [31:0] dat1;
        logic [31:0] dat2;
        logic [3:0]  par1;
        logic [3:0]  par2;
    } dpbr_port_s;

    dpbr_port_s st_r;
    dpbr_port_s st_nxt;
    logic       edge_hit;
    logic [4:0] off;
    logic [1:0] poff;
    logic [31:0] wm;
    logic [3:0]  pm;

    // ************************************************************
    // Edge detect and lane mapping
    // ************************************************************
    always_comb begin
        st_nxt        = st_r;
        st_nxt.clk_sh = {st_r.clk_sh[1:0], port_clk};
        st_nxt.sel_sh = {st_r.sel_sh[0], select};
        st_nxt.we_sh  = {st_r.we_sh[0], write_strobe};
        st_nxt.addr1  = addr;
        st_nxt.addr2  = st_r.addr1;
        st_nxt.dat1   = wr_data;
        st_nxt.dat2   = st_r.dat1;
        st_nxt.par1   = wr_par;
        st_nxt.par2   = st_r.par1;
        edge_hit = falling ? (!st_r.clk_sh[1] && st_r.clk_sh[2])
                           : (st_r.clk_sh[1] && !st_r.clk_sh[2]);
        fire = edge_hit && st_r.sel_sh[1];
        wr   = fire && st_r.we_sh[1];
        poff = 2'h0;
        pm   = 4'h0;
        case (width)
            dpbr_pkg::DPBR_W1: begin
                word_idx = st_r.addr2[13:5];
                off      = st_r.addr2[4:0];
                wm       = 32'h0000_0001;
            end
            dpbr_pkg::DPBR_W2: begin
                word_idx = st_r.addr2[12:4];
                off      = {st_r.addr2[3:0], 1'h0};
                wm       = 32'h0000_0003;
            end
            dpbr_pkg::DPBR_W4: begin
                word_idx = st_r.addr2[11:3];
                off      = {st_r.addr2[2:0], 2'h0};
                wm       = 32'h0000_000F;
            end
            dpbr_pkg::DPBR_W9: begin
                word_idx = st_r.addr2[10:2];
                off      = {st_r.addr2[1:0], 3'h0};
                wm       = 32'h0000_00FF;
                poff     = st_r.addr2[1:0];
                pm       = 4'h1;
            end
            dpbr_pkg::DPBR_W18: begin
                word_idx = st_r.addr2[9:1];
                off      = {st_r.addr2[0], 4'h0};
                wm       = 32'h0000_FFFF;
                poff     = {st_r.addr2[0], 1'h0};
                pm       = 4'h3;
            end
            default: begin
                word_idx = st_r.addr2[8:0];
                off      = 5'h00;
                wm       = 32'hFFFF_FFFF;
                pm       = 4'hF;
            end
        endcase
        bit_mask  = wm << off;
        bit_data  = (st_r.dat2 & wm) << off;
        par_mask  = pm << poff;
        par_data  = (st_r.par2 & pm) << poff;
        rd_data   = (rd_word >> off) & wm;
        rd_parity = (rd_par >> poff) & pm;
        thru_data = st_r.dat2 & wm;
        thru_par  = st_r.par2 & pm;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : dpbr_port

// *** hdl/dpbr_top.sv ***
/*
 * Dual-port 18 Kb block memory with per-port width, write mode and
 * clock polarity set over AXI4-Lite.
 * Assumes port clocks are slow against aclk and port inputs are held
 * steady for at least three aclk periods around each port clock edge.
 */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module dpbr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        port_a_clk,
    input  wire logic        port_a_select,
    input  wire logic        port_a_write_strobe,
    input  wire logic [13:0] port_a_addr,
    input  wire logic [31:0] port_a_write_data_in,
    input  wire logic [3:0]  port_a_write_parity_in,
    output logic [31:0]      port_a_read_data,
    output logic [3:0]       port_a_read_parity,
    input  wire logic        port_b_clk,
    input  wire logic        port_b_select,
    input  wire logic        port_b_write_strobe,
    input  wire logic [13:0] port_b_addr,
    input  wire logic [31:0] port_b_write_data_in,
    input  wire logic [3:0]  port_b_write_parity_in,
    output logic [31:0]      port_b_read_data,
    output logic [3:0]       port_b_read_parity
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0]       cfg;
        logic [1:0][31:0]  q_data;
        logic [1:0][3:0]   q_par;
        logic [1:0][15:0]  ops;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } dpbr_state_s;

    dpbr_state_s st_r;
    dpbr_state_s st_nxt;

    logic [31:0] mem_data [dpbr_pkg::WORDS];
    logic [3:0]  mem_par  [dpbr_pkg::WORDS];

    logic [1:0]        p_clk;
    logic [1:0]        p_sel;
    logic [1:0]        p_we;
    logic [1:0][13:0]  p_addr;
    logic [1:0][31:0]  p_din;
    logic [1:0][3:0]   p_pin;
    logic [1:0]        fire;
    logic [1:0]        wr;
    logic [1:0][8:0]   idx;
    logic [1:0][31:0]  bmask;
    logic [1:0][31:0]  bdata;
    logic [1:0][3:0]   pmask;
    logic [1:0][3:0]   pdata;
    logic [1:0][31:0]  rword;
    logic [1:0][3:0]   rpar;
    logic [1:0][31:0]  rdat;
    logic [1:0][3:0]   rprt;
    logic [1:0][31:0]  tdat;
    logic [1:0][3:0]   tprt;
    logic [31:0]       new_a_data;
    logic [3:0]        new_a_par;
    logic [31:0]       base_b_data;
    logic [3:0]        base_b_par;
    logic [31:0]       new_b_data;
    logic [3:0]        new_b_par;
    logic              aw_take;
    logic              ar_take;

    assign p_clk  = {port_b_clk, port_a_clk};
    assign p_sel  = {port_b_select, port_a_select};
    assign p_we   = {port_b_write_strobe, port_a_write_strobe};
    assign p_addr = {port_b_addr, port_a_addr};
    assign p_din  = {port_b_write_data_in, port_a_write_data_in};
    assign p_pin  = {port_b_write_parity_in, port_a_write_parity_in};

    // ************************************************************
    // Access ports
    // ************************************************************
    for (genvar g = 0; g < dpbr_pkg::PORTS; g++) begin : g_port
        assign rword[g] = mem_data[idx[g]];
        assign rpar[g]  = mem_par[idx[g]];
        dpbr_port u_port (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .port_clk     (p_clk[g]),
            .select       (p_sel[g]),
            .write_strobe (p_we[g]),
            .addr         (p_addr[g]),
            .wr_data      (p_din[g]),
            .wr_par       (p_pin[g]),
            .width        (dpbr_pkg::dpbr_width_e'(st_r.cfg[dpbr_pkg::CFG_WIDTH_LSB
                                                   + g * dpbr_pkg::CFG_PORT_STEP +: 3])),
            .falling      (st_r.cfg[dpbr_pkg::CFG_FALL_BIT + g]),
            .rd_word      (rword[g]),
            .rd_par       (rpar[g]),
            .fire         (fire[g]),
            .wr           (wr[g]),
            .word_idx     (idx[g]),
            .bit_mask     (bmask[g]),
            .bit_data     (bdata[g]),
            .par_mask     (pmask[g]),
            .par_data     (pdata[g]),
            .rd_data      (rdat[g]),
            .rd_parity    (rprt[g]),
            .thru_data    (tdat[g]),
            .thru_par     (tprt[g])
        );
    end

    // ************************************************************
    // Memory array
    // ************************************************************
    always_comb begin
        new_a_data  = (rword[0] & ~bmask[0]) | bdata[0];
        new_a_par   = (rpar[0] & ~pmask[0]) | pdata[0];
        base_b_data = (wr[0] && idx[0] == idx[1]) ? new_a_data : rword[1];
        base_b_par  = (wr[0] && idx[0] == idx[1]) ? new_a_par : rpar[1];
        new_b_data  = (base_b_data & ~bmask[1]) | bdata[1];
        new_b_par   = (base_b_par & ~pmask[1]) | pdata[1];
    end

    always_ff @(posedge aclk) begin
        if (wr[0]) begin
            mem_data[idx[0]] <= new_a_data;
            mem_par[idx[0]]  <= new_a_par;
        end
        if (wr[1]) begin
            mem_data[idx[1]] <= new_b_data;
            mem_par[idx[1]]  <= new_b_par;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt  = st_r;
        aw_take = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
        ar_take = s_axi_arvalid && !st_r.rvalid;
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'h0;
        end
        if (aw_take) begin
            st_nxt.bvalid = 1'h1;
            st_nxt.bresp  = dpbr_pkg::RESP_OKAY;
            if (s_axi_awaddr == dpbr_pkg::REG_CFG) begin
                for (int k = 0; k < 4; k++) begin
                    if (s_axi_wstrb[k]) begin
                        st_nxt.cfg[k * 8 +: 8] = s_axi_wdata[k * 8 +: 8];
                    end
                end
            end else if (s_axi_awaddr != dpbr_pkg::REG_STAT) begin
                st_nxt.bresp = dpbr_pkg::RESP_SLVERR;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'h0;
        end
        if (ar_take) begin
            st_nxt.rvalid = 1'h1;
            st_nxt.rresp  = dpbr_pkg::RESP_OKAY;
            if (s_axi_araddr == dpbr_pkg::REG_CFG) begin
                st_nxt.rdata = st_r.cfg;
            end else if (s_axi_araddr == dpbr_pkg::REG_STAT) begin
                st_nxt.rdata = {st_r.ops[1], st_r.ops[0]};
            end else begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rresp = dpbr_pkg::RESP_SLVERR;
            end
        end
        for (int i = 0; i < dpbr_pkg::PORTS; i++) begin
            if (fire[i]) begin
                st_nxt.ops[i] = st_r.ops[i] + 16'h0001;
                if (!wr[i]) begin
                    st_nxt.q_data[i] = rdat[i];
                    st_nxt.q_par[i]  = rprt[i];
                end else begin
                    case (dpbr_pkg::dpbr_mode_e'(st_r.cfg[dpbr_pkg::CFG_MODE_LSB
                                                  + i * dpbr_pkg::CFG_PORT_STEP +: 2]))
                        dpbr_pkg::DPBR_WRITE_THROUGH: begin
                            st_nxt.q_data[i] = tdat[i];
                            st_nxt.q_par[i]  = tprt[i];
                        end
                        dpbr_pkg::DPBR_READ_BEFORE_WRITE: begin
                            st_nxt.q_data[i] = rdat[i];
                            st_nxt.q_par[i]  = rprt[i];
                        end
                        default: begin
                            st_nxt.q_data[i] = st_r.q_data[i];
                            st_nxt.q_par[i]  = st_r.q_par[i];
                        end
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r     <= '0;
            st_r.cfg <= dpbr_pkg::CFG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready      = aw_take;
    assign s_axi_wready       = aw_take;
    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_arready      = ar_take;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rresp        = st_r.rresp;
    assign s_axi_rdata        = st_r.rdata;
    assign port_a_read_data   = st_r.q_data[0];
    assign port_a_read_parity = st_r.q_par[0];
    assign port_b_read_data   = st_r.q_data[1];
    assign port_b_read_parity = st_r.q_par[1];

endmodule : dpbr_top

// *** testbench/dpbr_top_sva.sv ***
/*
 * Port checks for the dual-port block memory.
 * Assumes binding into dpbr_top, one clock aclk.
 */
`timescale 1ns/10ps
module dpbr_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        port_a_clk,
    input wire logic        port_a_select,
    input wire logic [31:0] port_a_read_data,
    input wire logic [3:0]  port_a_read_parity,
    input wire logic        port_b_clk,
    input wire logic        port_b_select,
    input wire logic [31:0] port_b_read_data,
    input wire logic [3:0]  port_b_read_parity
);
    logic [3:0] a_age_r;
    logic [3:0] b_age_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ************************************************************
    // Cycles since a selected port clock change
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) a_age_r <= 4'hF;
        else if ($changed(port_a_clk) && port_a_select) a_age_r <= 4'h0;
        else if (a_age_r != 4'hF) a_age_r <= a_age_r + 4'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) b_age_r <= 4'hF;
        else if ($changed(port_b_clk) && port_b_select) b_age_r <= 4'h0;
        else if (b_age_r != 4'hF) b_age_r <= b_age_r + 4'h1;
    end
    a_out_cause_a: assert property ($changed({port_a_read_parity, port_a_read_data}) |-> a_age_r < 4'h8)
        else $error("port A output moved without a selected edge");
    b_out_cause_a: assert property ($changed({port_b_read_parity, port_b_read_data}) |-> b_age_r < 4'h8)
        else $error("port B output moved without a selected edge");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
        else $error("read response dropped");
endmodule : dpbr_top_sva

bind dpbr_top dpbr_top_sva dpbr_top_sva_i (.*);

// *** testbench/dpbr_port_model.sv ***
/*
 * User logic on one memory port: one clock pulse per operation.
 * Assumes aclk is the system clock; the port clock rests low.
 */
`timescale 1ns/10ps
module dpbr_port_model (
    input  wire logic  aclk,
    output logic       port_clk,
    output logic       select,
    output logic       write_strobe,
    output logic [13:0] addr,
    output logic [31:0] wdata,
    output logic [3:0]  wpar
);
    initial {port_clk, select, write_strobe, addr, wdata, wpar} = 53'h0;
    task automatic drive(input logic s, input logic w, input logic [13:0] a,
                         input logic [31:0] d, input logic [3:0] p);
        @(posedge aclk);
        {select, write_strobe, addr, wdata, wpar} <= {s, w, a, d, p};
        repeat (2) @(posedge aclk);
    endtask : drive
    task automatic edge_to(input logic v);
        port_clk <= v;
        repeat (6) @(posedge aclk);
    endtask : edge_to
    task automatic idle();
        {select, write_strobe, addr, wdata, wpar} <= {2'h0, ~addr, ~wdata, ~wpar};
    endtask : idle
    task automatic op(input logic s, input logic w, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] p);
        drive(s, w, a, d, p);
        edge_to(1'b1);
        edge_to(1'b0);
        idle();
    endtask : op
endmodule : dpbr_port_model

// *** testbench/dpbr_top_tb_top.sv ***
/*
 * Self-checking bench for the dual-port block memory.
 * Assumes the design package and the port model are compiled first.
 */
`timescale 1ns/10ps
module dpbr_top_tb_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, port_a_read_data, port_b_read_data, rd, d0, d1, d2, d3;
    logic [3:0]  s_axi_wstrb, port_a_read_parity, port_b_read_parity, p0, p1;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        port_a_clk, port_a_select, port_a_write_strobe, port_b_clk, port_b_select, port_b_write_strobe;
    logic [13:0] port_a_addr, port_b_addr, ad;
    logic [31:0] port_a_write_data_in, port_b_write_data_in;
    logic [3:0]  port_a_write_parity_in, port_b_write_parity_in;
    int          mismatches, cmp_count, cycles, cnt_a, cnt_b;
    dpbr_top dpbr_top_i (.*);
    dpbr_port_model port_a_model (.aclk, .port_clk(port_a_clk), .select(port_a_select),
        .write_strobe(port_a_write_strobe), .addr(port_a_addr), .wdata(port_a_write_data_in),
        .wpar(port_a_write_parity_in));
    dpbr_port_model port_b_model (.aclk, .port_clk(port_b_clk), .select(port_b_select),
        .write_strobe(port_b_write_strobe), .addr(port_b_addr), .wdata(port_b_write_data_in),
        .wpar(port_b_write_parity_in));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [35:0] lane(input int c, input logic [31:0] d, input logic [3:0] p);
        int dw = (c < 3) ? (1 << c) : (8 << (c - 3));
        int pw = (c < 3) ? 0 : (1 << (c - 3));
        lane = {p & 4'((1 << pw) - 1), d & 32'((64'h1 << dw) - 1)};
    endfunction : lane
    function automatic logic [35:0] out(input int pt);
        out = (pt == 0) ? {port_a_read_parity, port_a_read_data} : {port_b_read_parity, port_b_read_data};
    endfunction : out
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                check(36'(s_axi_bresp), 36'(er));
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic set_cfg(input logic [2:0] w, input logic [1:0] ma, input logic fb);
        axi_wr(dpbr_pkg::REG_CFG, {14'h0, fb, 7'h0, ma, 1'b0, w, 1'b0, w}, dpbr_pkg::RESP_OKAY);
    endtask : set_cfg
    task automatic op(input int pt, input logic s, input logic w, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] p);
        if (pt == 0) port_a_model.op(s, w, a, d, p);
        else port_b_model.op(s, w, a, d, p);
        if (pt == 0) cnt_a += int'(s);
        else cnt_b += int'(s);
    endtask : op
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'hF3C3));
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check(out(0) | out(1), 36'h0);
        axi_rd(dpbr_pkg::REG_CFG, rd, rr);
        check(36'(rd), 36'(dpbr_pkg::CFG_RESET));
        axi_wr(12'h010, 32'hFFFF_FFFF, dpbr_pkg::RESP_SLVERR);
        axi_rd(12'h010, rd, rr);
        check({2'h0, rr, rd}, {2'h0, dpbr_pkg::RESP_SLVERR, 32'h0});
        axi_wr(dpbr_pkg::REG_STAT, 32'hFFFF_FFFF, dpbr_pkg::RESP_OKAY);
        for (int c = 0; c < 6; c++) begin
            set_cfg(3'(c), 2'h0, 1'b0);
            ad = 14'((16384 >> c) - 2);
            {d0, d1, p0, p1} = {$urandom(), $urandom(), 4'($urandom()), 4'($urandom())};
            op(0, 1'b1, 1'b1, ad, d0, p0);
            check(out(0), lane(c, d0, p0));
            op(1, 1'b1, 1'b1, ad + 14'h1, d1, p1);
            op(0, 1'b1, 1'b0, ad, ~d0, ~p0);
            check(out(0), lane(c, d0, p0));
            op(1, 1'b1, 1'b0, ad + 14'h1, ~d1, ~p1);
            check(out(1), lane(c, d1, p1));
        end
        ad = 14'($urandom_range(0, 511));
        {d0, d1, d2, d3} = {$urandom(), $urandom(), $urandom(), $urandom()};
        op(0, 1'b1, 1'b1, ad, d0, p0);
        set_cfg(3'h5, 2'h1, 1'b0);
        op(0, 1'b1, 1'b1, ad, d1, p0);
        check(out(0), {p0, d0});
        set_cfg(3'h5, 2'h2, 1'b0);
        op(0, 1'b1, 1'b0, ad, d0, p1);
        check(out(0), {p0, d1});
        op(0, 1'b1, 1'b1, ad, d2, p1);
        check(out(0), {p0, d1});
        set_cfg(3'h5, 2'h3, 1'b0);
        op(0, 1'b1, 1'b1, ad, d3, p1);
        check(out(0), {p0, d1});
        op(0, 1'b0, 1'b1, ad, ~d3, ~p1);
        check(out(0), {p0, d1});
        op(1, 1'b1, 1'b0, ad, d0, p0);
        check(out(1), {p1, d3});
        set_cfg(3'h5, 2'h0, 1'b1);
        port_b_model.drive(1'b1, 1'b1, ad, d2, p0);
        port_b_model.edge_to(1'b1);
        check(out(1), {p1, d3});
        port_b_model.edge_to(1'b0);
        check(out(1), {p0, d2});
        port_b_model.idle();
        cnt_b++;
        set_cfg(3'h5, 2'h0, 1'b0);
        repeat (8) begin
            ad = 14'($urandom_range(0, 511));
            {d0, p0} = {$urandom(), 4'($urandom())};
            op(0, 1'b1, 1'b1, ad, d0, p0);
            op(1, 1'b1, 1'b0, ad, ~d0, ~p0);
            check(out(1), {p0, d0});
        end
        axi_rd(dpbr_pkg::REG_STAT, rd, rr);
        check(36'(rd), {4'h0, 16'(cnt_b), 16'(cnt_a)});
        test_done();
    end
endmodule : dpbr_top_tb_top
